// File: src/ucs_ctrl.sv
`timescale 1ns/1ps
`include "ucs_map.svh"
// Operation
// - regulator bit drives or releases regulator pin
// - select 1: long low data line interrupts
// - select 0: long SE0 gives bus reset
// - non-idle line sets sticky activity flag
// - write 0 clears activity, 1 keeps
// - forcing codes 001 to 011 drive K, J, SE0; 000 forces nothing
// - forcing codes 1xx open-drain pulls per line
// - address cleared by reset and bus reset
// - respond only when enabled and address matches
// - control endpoint buffer sits at f8 to ff
// - engine update locks mode register until read
// - unlocked write clears mode bits 7 to 4
// - setup flag held; blocks buffer writes meanwhile
// - in and out flags set after transaction
// - ack flag set on acked transaction
// - mode 0001: nak in/out, ack setup
// - mode 1011: ack out then mode 0001
// - bit 7 connects ps2 pull-ups
// - line levels readable in auxiliary port
module ucs_ctrl #(
    parameter int AW    = 12,
    parameter int DET_W = 12
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [AW-1:0]   paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            dp_i,
    input  wire logic            dm_i,
    output logic                 dp_o,
    output logic                 dp_oe_n,
    output logic                 dm_o,
    output logic                 dm_oe_n,
    input  wire logic            regulator_output_pin_i,
    output logic                 regulator_output_pin_o,
    output logic                 regulator_output_pin_oe_n,
    output logic                 ps2_pullup_en,
    output logic                 bus_reset_pulse,
    output logic                 ps2_activity_pulse,
    input  wire logic            eng_drive,
    input  wire logic            eng_dp,
    input  wire logic            eng_dm,
    input  wire logic            tok_valid,
    input  wire ucs_pkg::ucs_pid_t tok_pid,
    input  wire logic [6:0]      tok_addr,
    input  wire logic            tok_ep0,
    output logic                 addr_hit,
    output ucs_pkg::ucs_hs_t     hs_code,
    input  wire logic            ev_setup_data,
    input  wire logic            ev_ack_start,
    input  wire logic            ev_in_done,
    input  wire logic            ev_out_done,
    input  wire logic            ev_acked,
    input  wire logic            buf_wr_en,
    input  wire logic [7:0]      buf_wr_addr,
    output logic                 ep0_buf_we
);
    import ucs_pkg::*;

    localparam logic [DET_W-1:0] DET_MIN = DET_W'(`UCS_DET_MIN_CYC);
    localparam logic [2:0]       PIN_IDLE = `UCS_PIN_IDLE;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    assign pin_raw = {regulator_output_pin_i, dm_i, dp_i};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                // reset to idle levels, so release is not taken for activity or se0
                if (!presetn) begin
                    sync1_q[g] <= PIN_IDLE[g];
                    sync2_q[g] <= PIN_IDLE[g];
                end else begin
                    sync1_q[g] <= pin_raw[g];
                    sync2_q[g] <= sync1_q[g];
                end
            end
        end
    endgenerate

    logic dp_s;
    logic dm_s;
    logic regulator_output_pin_s;
    assign dp_s   = sync2_q[0];
    assign dm_s   = sync2_q[1];
    assign regulator_output_pin_s = sync2_q[2];

    // ------------------------------------------------------------
    // apb slave: one wait state, answer from flops
    // ------------------------------------------------------------
    logic [`UCS_IDX_W-1:0] idx;
    logic                  hit_aux;
    logic                  hit_addr;
    logic                  hit_ep0;
    logic                  hit_sc;
    logic                  mapped;
    logic                  do_wr;
    logic                  do_rd;
    logic                  pready_q;
    logic [31:0]           prdata_q;
    logic                  pslverr_q;

    assign idx      = paddr[`UCS_IDX_W+1:2];
    assign mapped   = (paddr[1:0] == 2'h0) && (paddr[AW-1:`UCS_IDX_W+2] == '0);
    assign hit_aux  = mapped && idx == `UCS_IDX_AUX;
    assign hit_addr = mapped && idx == `UCS_IDX_ADDR;
    assign hit_ep0  = mapped && idx == `UCS_IDX_EP0MODE;
    assign hit_sc   = mapped && idx == `UCS_IDX_STATCTL;
    assign do_wr    = psel && penable && pready_q && pwrite;
    assign do_rd    = psel && penable && pready_q && !pwrite;

    logic       pullup_q;
    logic       regulator_output_pin_q;
    logic       irqsel_q;
    logic       act_q;
    logic [2:0] force_q;
    logic [7:0] addr_q;
    logic       setup_q;
    logic       in_q;
    logic       out_q;
    logic       ack_q;
    logic [3:0] mode_q;
    logic [7:0] rd_d;

    always_comb begin
        rd_d = `UCS_RST_BYTE;
        if (hit_aux) begin
            rd_d[`UCS_AUX_DP]   = dp_s;
            rd_d[`UCS_AUX_DM]   = dm_s;
            rd_d[`UCS_AUX_REGULATOR_OUTPUT_PIN] = regulator_output_pin_s;
        end else if (hit_addr) begin
            rd_d = addr_q;
        end else if (hit_ep0) begin
            rd_d = {setup_q, in_q, out_q, ack_q, mode_q};
        end else if (hit_sc) begin
            // reserved bit 4 reads as zero whatever was written
            rd_d = {pullup_q, regulator_output_pin_q, irqsel_q, 1'h0, act_q, force_q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'h0;
            prdata_q  <= '0;
            pslverr_q <= 1'h0;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            if (psel && penable && !pready_q) begin
                prdata_q  <= {24'h0, rd_d};
                pslverr_q <= !(hit_aux || hit_addr || hit_ep0 || hit_sc);
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // status and control register
    // ------------------------------------------------------------
    logic line_busy;
    // idle for low speed is J: D- high, D+ low
    assign line_busy = !(dm_s && !dp_s);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_q <= 1'h0;
            regulator_output_pin_q   <= 1'h0;
            irqsel_q <= 1'h0;
            force_q  <= `UCS_RST_FORCE;
        end else if (do_wr && hit_sc) begin
            pullup_q <= pwdata[`UCS_SC_PULLUP];
            regulator_output_pin_q   <= pwdata[`UCS_SC_REGULATOR_OUTPUT_PIN];
            irqsel_q <= pwdata[`UCS_SC_IRQSEL];
            force_q  <= pwdata[`UCS_SC_FRC_HI:`UCS_SC_FRC_LO];
        end
    end

    // a set in the same cycle as a clearing write wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_q <= 1'h0;
        end else if (line_busy) begin
            act_q <= 1'h1;
        end else if (do_wr && hit_sc && !pwdata[`UCS_SC_ACT]) begin
            act_q <= 1'h0;
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    logic dp_o_d;
    logic dm_o_d;
    logic dp_oe_n_d;
    logic dm_oe_n_d;
    logic dp_o_q;
    logic dm_o_q;
    logic dp_oe_n_q;
    logic dm_oe_n_q;
    logic regulator_output_pin_oe_n_q;
    logic regulator_output_pin_o_q;
    logic pullup_o_q;

    always_comb begin
        dp_o_d    = eng_dp;
        dm_o_d    = eng_dm;
        dp_oe_n_d = !eng_drive;
        dm_oe_n_d = !eng_drive;
        if (force_q[`UCS_F_OD_BIT]) begin
            dp_o_d    = 1'h0;
            dm_o_d    = 1'h0;
            dp_oe_n_d = force_q[`UCS_F_DP_REL_BIT];
            dm_oe_n_d = force_q[`UCS_F_DM_REL_BIT];
        end else if (force_q != `UCS_F_NONE) begin
            dp_oe_n_d = 1'h0;
            dm_oe_n_d = 1'h0;
            dp_o_d    = (force_q == `UCS_F_K);
            dm_o_d    = (force_q == `UCS_F_J);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dp_o_q      <= 1'h0;
            dm_o_q      <= 1'h0;
            dp_oe_n_q   <= 1'h1;
            dm_oe_n_q   <= 1'h1;
            regulator_output_pin_o_q    <= 1'h0;
            regulator_output_pin_oe_n_q <= 1'h1;
            pullup_o_q  <= 1'h0;
        end else begin
            dp_o_q      <= dp_o_d;
            dm_o_q      <= dm_o_d;
            dp_oe_n_q   <= dp_oe_n_d;
            dm_oe_n_q   <= dm_oe_n_d;
            regulator_output_pin_o_q    <= regulator_output_pin_q;
            regulator_output_pin_oe_n_q <= !regulator_output_pin_q;
            pullup_o_q  <= pullup_q;
        end
    end

    assign dp_o                      = dp_o_q;
    assign dm_o                      = dm_o_q;
    assign dp_oe_n                   = dp_oe_n_q;
    assign dm_oe_n                   = dm_oe_n_q;
    assign regulator_output_pin_o    = regulator_output_pin_o_q;
    assign regulator_output_pin_oe_n = regulator_output_pin_oe_n_q;
    assign ps2_pullup_en             = pullup_o_q;

    // ------------------------------------------------------------
    // long line-condition detector
    // ------------------------------------------------------------
    logic             det_cond;
    logic [DET_W-1:0] det_cnt_q;
    logic             bus_rst_q;
    logic             ps2_act_q;
    logic             det_fire;

    // one counter serves both modes; a mode change mid-run restarts nothing,
    // which is harmless since the select is static in practice
    assign det_cond = irqsel_q ? !dm_s : (!dp_s && !dm_s);
    assign det_fire = det_cond && (det_cnt_q == DET_MIN - DET_W'(1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_cnt_q <= '0;
        end else if (!det_cond) begin
            det_cnt_q <= '0;
        end else if (det_cnt_q != DET_MIN) begin
            det_cnt_q <= det_cnt_q + DET_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_rst_q <= 1'h0;
            ps2_act_q <= 1'h0;
        end else begin
            bus_rst_q <= det_fire && !irqsel_q;
            ps2_act_q <= det_fire && irqsel_q;
        end
    end

    assign bus_reset_pulse    = bus_rst_q;
    assign ps2_activity_pulse = ps2_act_q;

    // ------------------------------------------------------------
    // device address and token answer
    // ------------------------------------------------------------
    logic    hit_d;
    logic    addr_hit_q;
    ucs_hs_t hs_d;
    ucs_hs_t hs_q;
    logic    auto_nak;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= `UCS_RST_BYTE;
        end else if (det_fire && !irqsel_q) begin
            addr_q <= `UCS_RST_BYTE;
        end else if (do_wr && hit_addr) begin
            addr_q <= pwdata[7:0];
        end
    end

    assign hit_d = tok_valid && addr_q[`UCS_AD_EN] && (tok_addr == addr_q[6:0]);

    always_comb begin
        hs_d = UCS_HS_NONE;
        if (hit_d && tok_ep0) begin
            unique case (tok_pid)
                UCS_PID_SETUP: hs_d = UCS_HS_ACK;
                UCS_PID_IN:    hs_d = UCS_HS_NAK;
                UCS_PID_OUT:   hs_d = (mode_q == `UCS_MODE_ACKOUT) ? UCS_HS_ACK
                                                                   : UCS_HS_NAK;
                default:       hs_d = UCS_HS_NONE;
            endcase
        end
    end

    assign auto_nak = hit_d && tok_ep0 && tok_pid == UCS_PID_OUT
                      && mode_q == `UCS_MODE_ACKOUT;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_hit_q <= 1'h0;
            hs_q       <= UCS_HS_NONE;
        end else begin
            addr_hit_q <= hit_d;
            hs_q       <= hs_d;
        end
    end

    assign addr_hit = addr_hit_q;
    assign hs_code  = hs_q;

    // ------------------------------------------------------------
    // control endpoint mode register
    // ------------------------------------------------------------
    logic lock_q;
    logic hold_q;
    logic eng_upd;
    logic wr_ok;

    assign eng_upd = ev_in_done || ev_out_done || ev_acked || auto_nak;
    assign wr_ok   = do_wr && hit_ep0 && !lock_q;

    // an update in the same cycle as the unlocking read keeps the lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= 1'h0;
        end else if (eng_upd) begin
            lock_q <= 1'h1;
        end else if (do_rd && hit_ep0) begin
            lock_q <= 1'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 1'h0;
        end else if (ev_setup_data) begin
            hold_q <= 1'h1;
        end else if (ev_ack_start) begin
            hold_q <= 1'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_q <= 1'h0;
        end else if (ev_setup_data || hold_q) begin
            setup_q <= 1'h1;
        end else if (wr_ok) begin
            setup_q <= 1'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_q  <= 1'h0;
            out_q <= 1'h0;
            ack_q <= 1'h0;
        end else begin
            in_q  <= ev_in_done  || (in_q  && !wr_ok);
            out_q <= ev_out_done || (out_q && !wr_ok);
            ack_q <= ev_acked    || (ack_q && !wr_ok);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 4'h0;
        end else if (auto_nak) begin
            mode_q <= `UCS_MODE_NAK_IO;
        end else if (wr_ok) begin
            mode_q <= pwdata[3:0];
        end
    end

    // buffer writes inside the window are dropped while setup is flagged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ep0_buf_we <= 1'h0;
        end else begin
            ep0_buf_we <= buf_wr_en && !(setup_q && buf_wr_addr >= `UCS_BUF_LO
                                         && buf_wr_addr <= `UCS_BUF_HI);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [12:0] run_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= '0;
        end else if (!det_cond) begin
            run_q <= '0;
        end else if (run_q != 13'h1fff) begin
            run_q <= run_q + 13'h1;
        end
    end

    property p_regulator_output_pin;
        $rose(regulator_output_pin_q) |=> !regulator_output_pin_oe_n && regulator_output_pin_o;
    endproperty
    a_regulator_output_pin: assert property (p_regulator_output_pin) else $error("regulator pin not driven");

    property p_det_window;
        (bus_reset_pulse || ps2_activity_pulse) |->
            $past(run_q) >= 13'h4ff && $past(run_q) <= 13'h9ff;
    endproperty
    a_det_window: assert property (p_det_window) else $error("detector timing");

    property p_busrst_mode;
        bus_reset_pulse |-> !$past(irqsel_q) && $past(!dp_s && !dm_s);
    endproperty
    a_busrst_mode: assert property (p_busrst_mode) else $error("bus reset cause");

    property p_act_sticky;
        act_q && !(do_wr && hit_sc) |=> act_q;
    endproperty
    a_act_sticky: assert property (p_act_sticky) else $error("activity lost");

    property p_act_clear;
        do_wr && hit_sc && !pwdata[`UCS_SC_ACT] && !line_busy |=> !act_q;
    endproperty
    a_act_clear: assert property (p_act_clear) else $error("activity not cleared");

    property p_force_k;
        force_q == `UCS_F_K |=> dp_o && !dm_o && !dp_oe_n && !dm_oe_n;
    endproperty
    a_force_k: assert property (p_force_k) else $error("force K wrong");

    property p_force_od;
        force_q[`UCS_F_OD_BIT] |=> !dp_o && !dm_o && dm_oe_n == $past(force_q[1])
                                   && dp_oe_n == $past(force_q[0]);
    endproperty
    a_force_od: assert property (p_force_od) else $error("open-drain wrong");

    property p_addr_clr;
        bus_reset_pulse |-> addr_q == `UCS_RST_BYTE;
    endproperty
    a_addr_clr: assert property (p_addr_clr) else $error("address kept");

    property p_lock;
        lock_q && do_wr && hit_ep0 && !eng_upd |=> $stable(mode_q);
    endproperty
    a_lock: assert property (p_lock) else $error("locked write took");

    property p_setup_hold;
        ev_setup_data ##1 !ev_ack_start [*2] |-> setup_q;
    endproperty
    a_setup_hold: assert property (p_setup_hold) else $error("setup flag dropped");

    property p_auto;
        hs_code == UCS_HS_ACK && $past(tok_pid) == UCS_PID_OUT
            |-> mode_q == `UCS_MODE_NAK_IO;
    endproperty
    a_auto: assert property (p_auto) else $error("mode not changed");

    property p_unmatched;
        tok_valid && !addr_q[`UCS_AD_EN] |=> !addr_hit && hs_code == UCS_HS_NONE;
    endproperty
    a_unmatched: assert property (p_unmatched) else $error("answered disabled");

    c_busrst: cover property (bus_reset_pulse);
    c_ps2:    cover property (ps2_activity_pulse);
    c_auto:   cover property (auto_nak);
    c_lockrd: cover property (lock_q && do_rd && hit_ep0);
endmodule

// File: src/ucs_map.svh
`ifndef UCS_MAP_SVH
`define UCS_MAP_SVH

// register indices; the byte address on the bus is four times the index
`define UCS_IDX_AUX        8'h02
`define UCS_IDX_ADDR       8'h10
`define UCS_IDX_EP0MODE    8'h12
`define UCS_IDX_STATCTL    8'h1f
`define UCS_IDX_W          8

// status and control fields
`define UCS_SC_PULLUP      7
`define UCS_SC_REGULATOR_OUTPUT_PIN        6
`define UCS_SC_IRQSEL      5
`define UCS_SC_ACT         3
`define UCS_SC_FRC_HI      2
`define UCS_SC_FRC_LO      0

// auxiliary input port fields
`define UCS_AUX_DP         5
`define UCS_AUX_DM         4
`define UCS_AUX_REGULATOR_OUTPUT_PIN       0

// address register and control endpoint mode fields
`define UCS_AD_EN          7
`define UCS_EM_SETUP       7
`define UCS_EM_IN          6
`define UCS_EM_OUT         5
`define UCS_EM_ACK         4

`define UCS_RST_BYTE       8'h00
`define UCS_RST_FORCE      3'h0
// idle pin levels {regulator, d-, d+}: low-speed idle is d- high, d+ low
`define UCS_PIN_IDLE       3'h2

// line-condition detector timing
`define UCS_CLK_NS         100
`define UCS_DET_MIN_NS     128000
`define UCS_DET_MAX_NS     256000
`define UCS_DET_MIN_CYC    ((`UCS_DET_MIN_NS + `UCS_CLK_NS - 1) / `UCS_CLK_NS)
`define UCS_DET_MAX_CYC    (`UCS_DET_MAX_NS / `UCS_CLK_NS)

// endpoint modes
`define UCS_MODE_NAK_IO    4'h1
`define UCS_MODE_ACKOUT    4'hb

// forcing codes
`define UCS_F_NONE         3'h0
`define UCS_F_K            3'h1
`define UCS_F_J            3'h2
`define UCS_F_OD_BIT       2
`define UCS_F_DP_REL_BIT   0
`define UCS_F_DM_REL_BIT   1

// control endpoint buffer window in data memory
`define UCS_BUF_LO         8'hf8
`define UCS_BUF_HI         8'hff

`endif

// File: src/ucs_pkg.sv
package ucs_pkg;

    typedef enum logic [1:0] {
        UCS_PID_SETUP,
        UCS_PID_IN,
        UCS_PID_OUT
    } ucs_pid_t;

    typedef enum logic [1:0] {
        UCS_HS_NONE,
        UCS_HS_ACK,
        UCS_HS_NAK
    } ucs_hs_t;

endpackage

// File: verif/ucs_host_model.sv
`timescale 1ns/1ps
// --------------------------
// host end of the d+/d- pair
// --------------------------
module ucs_host_model (
    input  wire logic dp_o,
    input  wire logic dp_oe_n,
    input  wire logic dm_o,
    input  wire logic dm_oe_n,
    input  wire logic hold_low,
    output logic      dp_i,
    output logic      dm_i
);
    // released d+ rests low on the host pull-down, d- high on its pull-up
    assign dp_i = !dp_oe_n ? dp_o : 1'b0;
    // holding d- low reads as se0 in usb mode and as a low data line in ps/2
    assign dm_i = !dm_oe_n ? dm_o : !hold_low;
endmodule

// File: verif/tb_ucs_ctrl.sv
`timescale 1ns/1ps
module tb_ucs_ctrl;
    import ucs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, hold_low, tok_valid, buf_wr_en;
    logic        pready, pslverr, dp_i, dm_i, dp_o, dp_oe_n, dm_o, dm_oe_n, rg_o, rg_oe_n;
    logic        pull_en, brst, pact, addr_hit, buf_we;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  buf_wr_addr, q;
    logic [6:0]  tok_addr;
    logic [4:0]  evs;
    ucs_pid_t    tok_pid;
    ucs_hs_t     hs_code;
    int          err_total, n_compared, n;

    ucs_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dp_i(dp_i), .dm_i(dm_i), .dp_o(dp_o), .dp_oe_n(dp_oe_n),
        .dm_o(dm_o), .dm_oe_n(dm_oe_n), .regulator_output_pin_i(!rg_oe_n && rg_o),
        .regulator_output_pin_o(rg_o), .regulator_output_pin_oe_n(rg_oe_n),
        .ps2_pullup_en(pull_en), .bus_reset_pulse(brst), .ps2_activity_pulse(pact),
        .eng_drive(1'b0), .eng_dp(1'b0), .eng_dm(1'b0), .tok_valid(tok_valid),
        .tok_pid(tok_pid), .tok_addr(tok_addr), .tok_ep0(1'b1), .addr_hit(addr_hit),
        .hs_code(hs_code), .ev_setup_data(evs[4]), .ev_ack_start(evs[3]),
        .ev_in_done(evs[2]), .ev_out_done(evs[1]), .ev_acked(evs[0]),
        .buf_wr_en(buf_wr_en), .buf_wr_addr(buf_wr_addr), .ep0_buf_we(buf_we));

    ucs_host_model host_u (.dp_o(dp_o), .dp_oe_n(dp_oe_n), .dm_o(dm_o), .dm_oe_n(dm_oe_n),
        .hold_low(hold_low), .dp_i(dp_i), .dm_i(dm_i));

    // -----
    // tasks
    // -----
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(q, e);
    endtask
    // pulse must land 1280 cycles after the synced condition, well inside 2560
    task automatic det(input logic ps);
        hold_low <= 1'b1;
        n = 0;
        while (n < 2700 && (ps ? pact : brst) !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
        hold_low <= 1'b0;
        chk({7'h0, n > 1279 && n < 2564}, 8'h01);
    endtask
    task automatic tok(input ucs_pid_t p, input logic [6:0] a, input ucs_hs_t e);
        @(posedge pclk);
        tok_valid <= 1'b1;
        tok_pid <= p;
        tok_addr <= a;
        @(posedge pclk);
        tok_valid <= 1'b0;
        @(posedge pclk);
        chk({5'h0, addr_hit, hs_code}, {5'h0, e != UCS_HS_NONE, e});
    endtask
    task automatic ev(input logic [4:0] v);
        @(posedge pclk);
        evs <= v;
        @(posedge pclk);
        evs <= 5'h0;
    endtask
    task automatic bw(input logic [7:0] a, input logic e);
        @(posedge pclk);
        buf_wr_en <= 1'b1;
        buf_wr_addr <= a;
        @(posedge pclk);
        buf_wr_en <= 1'b0;
        @(posedge pclk);
        chk({7'h0, buf_we}, {7'h0, e});
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // --------
    // sequence
    // --------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        test_done();
    end
    initial begin
        {presetn, psel, penable, pwrite, hold_low, tok_valid, buf_wr_en} = 7'h0;
        {paddr, pwdata, buf_wr_addr, tok_addr, evs} = '0;
        tok_pid = UCS_PID_SETUP;
        err_total = 0;
        n_compared = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h040, 8'h00);
        rd(12'h048, 8'h00);
        rd(12'h07c, 8'h00);
        rd(12'h100, 8'h00);
        chk({7'h0, pslverr}, 8'h01);
        $display("test reset done");
        // 111 goes first so the open-drain codes start from released lines
        for (int c = 7; c >= 0; c--) begin
            apb(1'b1, 12'h07c, 8'(c));
            repeat (4) @(posedge pclk);
            chk({4'h0, dp_oe_n, dm_oe_n, dp_o & !dp_oe_n, dm_o & !dm_oe_n},
                {4'h0, c == 0 || (c > 3 && c[0]), c == 0 || (c > 3 && c[1]),
                 c == 1, c == 2});
            rd(12'h008, {2'b0, c == 1, c == 2 || c == 0 || c > 5, 4'h0});
        end
        apb(1'b1, 12'h07c, 8'hc0);
        repeat (4) @(posedge pclk);
        chk({5'h0, pull_en, rg_o, rg_oe_n}, 8'h06);
        rd(12'h008, 8'h11);
        rd(12'h07c, 8'hc0);
        $display("test pins done");
        apb(1'b1, 12'h040, 8'h85);
        det(1'b0);
        rd(12'h040, 8'h00);
        rd(12'h07c, 8'hc8);
        apb(1'b1, 12'h07c, 8'hc8);
        rd(12'h07c, 8'hc8);
        apb(1'b1, 12'h07c, 8'he0);
        rd(12'h07c, 8'he0);
        det(1'b1);
        $display("test detect done");
        tok(UCS_PID_SETUP, 7'h00, UCS_HS_NONE);
        apb(1'b1, 12'h040, 8'h85);
        apb(1'b1, 12'h048, 8'h0b);
        tok(UCS_PID_IN, 7'h05, UCS_HS_NAK);
        tok(UCS_PID_OUT, 7'h06, UCS_HS_NONE);
        tok(UCS_PID_OUT, 7'h05, UCS_HS_ACK);
        apb(1'b1, 12'h048, 8'h0b);
        rd(12'h048, 8'h01);
        tok(UCS_PID_OUT, 7'h05, UCS_HS_NAK);
        tok(UCS_PID_SETUP, 7'h05, UCS_HS_ACK);
        apb(1'b1, 12'h048, 8'hf7);
        rd(12'h048, 8'h07);
        tok(UCS_PID_OUT, 7'h05, UCS_HS_NAK);
        apb(1'b1, 12'h048, 8'h01);
        ev(5'h05);
        rd(12'h048, 8'h51);
        ev(5'h02);
        rd(12'h048, 8'h71);
        ev(5'h10);
        bw(8'hf8, 1'b0);
        bw(8'hf0, 1'b1);
        rd(12'h048, 8'hf1);
        apb(1'b1, 12'h048, 8'h01);
        rd(12'h048, 8'h81);
        ev(5'h08);
        bw(8'hff, 1'b0);
        apb(1'b1, 12'h048, 8'h01);
        rd(12'h048, 8'h01);
        bw(8'hff, 1'b1);
        $display("test endpoint done");
        test_done();
    end
endmodule
